// ==== shared/ebrc_defines.svh ====
// Constants for the external bus and reset control block
`ifndef EBRC_DEFINES_SVH
`define EBRC_DEFINES_SVH
// Oscillator cycles per state time, and state times in the reset sequence
`define EBRC_STATE_TIME_CYC 2'h3
`define EBRC_RESET_STATE_TIMES 4'hA
// Mapped code range that may live on chip
`define EBRC_INT_LO 16'h2000
`define EBRC_INT_HI 16'h3FFF
// Chip configuration register field positions
`define EBRC_CCR_ADV_BIT 0
`define EBRC_CCR_WAIT_LSB 1
`define EBRC_CCR_WAIT_MSB 2
// Request FIFO shape: write flag, 16-bit address, 8-bit data
`define EBRC_FIFO_DEPTH 16
`define EBRC_REQ_WIDTH 25
// Standby register file size
`define EBRC_RETAIN_BYTES 16
`define EBRC_RETAIN_AW 4
`endif

// ==== shared/ebrc_pkg.sv ====
// Types for the external bus and reset control block
package ebrc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_DATA,
        ST_WAIT,
        ST_END
    } ebrc_state_type;
endpackage

// ==== hdl/ebrc_fifo.sv ====
// Request FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module ebrc_fifo #(
    parameter int WIDTH = 25,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0] cnt_q;
    logic push;
    logic pop;

    // Honest full and empty from the occupancy count
    assign in_ready = (cnt_q != DEPTH[AW:0]);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem_q[rd_q];
    assign push = ce && in_valid && in_ready;
    assign pop = ce && out_valid && out_ready;

    // Storage, no reset needed
    always_ff @(posedge clock) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_q <= '0;
            rd_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule
`default_nettype wire

// ==== hdl/ebrc_retain_mem.sv ====
// Standby register file bytes, kept across reset
`timescale 1ns/1ps
`default_nettype none
module ebrc_retain_mem #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic clock,
    input wire logic ce,
    input wire logic we,
    input wire logic [$clog2(DEPTH)-1:0] addr,
    input wire logic [WIDTH-1:0] wdata,
    output logic [WIDTH-1:0] rdata
);
    logic [WIDTH-1:0] mem_q [DEPTH];

    // No reset: contents survive while standby supply holds
    always_ff @(posedge clock) begin
        if (ce) begin
            if (we) begin
                mem_q[addr] <= wdata;
            end
            rdata <= mem_q[addr];
        end
    end
endmodule
`default_nettype wire

// ==== hdl/ebrc_external_bus.sv ====
// External memory bus control, memory select and reset sequencing
`timescale 1ns/1ps
`default_nettype none
`include "ebrc_defines.svh"
module ebrc_external_bus
    import ebrc_pkg::*;
(
    input wire logic clock,
    input wire logic resetn,
    input wire logic ce,
    input wire logic memory_select_input,
    input wire logic prog_voltage_detect,
    input wire logic [2:0] chip_configuration_register,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [15:0] req_addr,
    input wire logic [7:0] req_wdata,
    output logic rsp_valid_q,
    output logic [7:0] rsp_rdata_q,
    output logic rsp_external_q,
    input wire logic [7:0] int_rdata,
    input wire logic retain_we,
    input wire logic [3:0] retain_addr,
    input wire logic [7:0] retain_wdata,
    output logic [7:0] retain_rdata,
    output logic bus_clock_output_q,
    output logic address_valid_strobe_q,
    output logic rd_n_q,
    output logic wr_n_q,
    output logic ready_unused_n,
    input wire logic ready,
    input wire logic [7:0] ad_in,
    output logic [7:0] ad_out_q,
    output logic ad_oe_q,
    output logic [7:0] addr_hi_out_q,
    output logic addr_hi_oe_q,
    output logic reset_busy_q,
    output logic program_mode_q
);
    ebrc_state_type state_q;
    ebrc_state_type state_d;
    logic [1:0] phase_q;
    logic tick;
    logic [3:0] seq_q;
    logic [1:0] wait_cnt_q;
    logic [1:0] wait_lim;
    logic adv_mode;
    logic [`EBRC_REQ_WIDTH-1:0] fifo_out;
    logic fifo_valid;
    logic pop;
    logic f_write;
    logic [15:0] f_addr;
    logic [7:0] f_wdata;
    logic hit_range;
    logic go_int;
    logic go_ext;
    logic cur_write_q;
    logic [15:0] cur_addr_q;
    logic [7:0] cur_wdata_q;
    logic may_wait;
    logic finish;
    logic [15:0] addr_next;

    assign adv_mode = chip_configuration_register[`EBRC_CCR_ADV_BIT];
    assign wait_lim = chip_configuration_register[`EBRC_CCR_WAIT_MSB:`EBRC_CCR_WAIT_LSB];
    assign tick = ce && (phase_q == `EBRC_STATE_TIME_CYC - 2'h1);
    assign {f_write, f_addr, f_wdata} = fifo_out;
    assign ready_unused_n = 1'b1;

    // Requests queue up ahead of the bus engine
    ebrc_fifo #(
        .WIDTH(`EBRC_REQ_WIDTH),
        .DEPTH(`EBRC_FIFO_DEPTH)
    ) u_fifo (
        .clock(clock),
        .resetn(resetn),
        .ce(ce),
        .in_valid(req_valid),
        .in_ready(req_ready),
        .in_data({req_write, req_addr, req_wdata}),
        .out_valid(fifo_valid),
        .out_ready(pop),
        .out_data(fifo_out)
    );

    // Retained bytes; writes are shut out while reset is held
    ebrc_retain_mem #(
        .WIDTH(8),
        .DEPTH(`EBRC_RETAIN_BYTES)
    ) u_retain (
        .clock(clock),
        .ce(ce),
        .we(retain_we && resetn),
        .addr(retain_addr),
        .wdata(retain_wdata),
        .rdata(retain_rdata)
    );

    // Routing of a queued request
    assign hit_range = (f_addr >= `EBRC_INT_LO) && (f_addr <= `EBRC_INT_HI);
    assign go_int = fifo_valid && hit_range && memory_select_input;
    assign go_ext = fifo_valid && !go_int;
    // Nothing leaves the queue during reset sequence or programming mode
    assign pop = ce && !reset_busy_q && !program_mode_q && state_q == ST_IDLE
        && (go_int || (go_ext && tick));

    // Wait permitted when no limit is set or the limit is not yet reached
    assign may_wait = (wait_lim == 2'h0) || (wait_cnt_q < wait_lim);
    assign finish = tick && (ready || !may_wait);
    // Address of the access now starting, so the first address cycle is already right
    assign addr_next = pop ? f_addr : cur_addr_q;

    // Phase counter sets the state time; held at zero in reset to resync
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            phase_q <= 2'h0;
        end else if (ce) begin
            if (tick) begin
                phase_q <= 2'h0;
            end else begin
                phase_q <= phase_q + 2'h1;
            end
        end
    end

    // Bus clock high in the first phase of each state time
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            bus_clock_output_q <= 1'b0;
        end else if (ce) begin
            bus_clock_output_q <= tick;
        end
    end

    // Reset sequence of ten state times after release
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            seq_q <= 4'h0;
            reset_busy_q <= 1'b1;
        end else if (tick && reset_busy_q) begin
            if (seq_q == `EBRC_RESET_STATE_TIMES - 4'h1) begin
                reset_busy_q <= 1'b0;
            end
            seq_q <= seq_q + 4'h1;
        end
    end

    // Programming mode follows the high-voltage detector
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            program_mode_q <= 1'b0;
        end else if (ce) begin
            program_mode_q <= prog_voltage_detect;
        end
    end

    // Next bus state; ready only matters in data and wait states
    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_IDLE: begin
                if (pop && go_ext) begin
                    state_d = ST_ADDR;
                end
            end
            ST_ADDR: begin
                if (tick) begin
                    state_d = ST_DATA;
                end
            end
            ST_DATA, ST_WAIT: begin
                if (finish) begin
                    state_d = ST_END;
                end else if (tick) begin
                    state_d = ST_WAIT;
                end
            end
            ST_END: begin
                if (tick) begin
                    state_d = ST_IDLE;
                end
            end
            default: begin
                state_d = ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_q <= ST_IDLE;
        end else if (ce) begin
            state_q <= state_d;
        end
    end

    // Wait state counter, cleared at the start of each cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wait_cnt_q <= 2'h0;
        end else if (ce) begin
            if (state_q == ST_ADDR) begin
                wait_cnt_q <= 2'h0;
            end else if (tick && !finish && wait_cnt_q != 2'h3) begin
                wait_cnt_q <= wait_cnt_q + 2'h1;
            end
        end
    end

    // Latch the request being run
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            cur_write_q <= 1'b0;
            cur_addr_q <= 16'h0000;
            cur_wdata_q <= 8'h00;
        end else if (pop) begin
            cur_write_q <= f_write;
            cur_addr_q <= f_addr;
            cur_wdata_q <= f_wdata;
        end
    end

    // Strobes decoded from the next state so they line up with state_q
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            address_valid_strobe_q <= 1'b1;
            rd_n_q <= 1'b1;
            wr_n_q <= 1'b1;
        end else if (ce) begin
            if (adv_mode) begin
                // Low from address phase through data, high at cycle end
                address_valid_strobe_q <= !(state_d == ST_ADDR || state_d == ST_DATA
                    || state_d == ST_WAIT);
            end else begin
                // Latch enable pulses high while the address is out
                address_valid_strobe_q <= (state_d == ST_ADDR);
            end
            rd_n_q <= !((state_d == ST_DATA || state_d == ST_WAIT) && !cur_write_q);
            wr_n_q <= !((state_d == ST_DATA || state_d == ST_WAIT) && cur_write_q);
        end
    end

    // Port pins: low address then data on one port, high address on the other
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            ad_out_q <= 8'h00;
            ad_oe_q <= 1'b0;
            addr_hi_out_q <= 8'h00;
            addr_hi_oe_q <= 1'b0;
        end else if (ce) begin
            addr_hi_out_q <= addr_next[15:8];
            addr_hi_oe_q <= (state_d != ST_IDLE);
            if (state_d == ST_ADDR) begin
                ad_out_q <= addr_next[7:0];
                ad_oe_q <= 1'b1;
            end else if (state_d != ST_IDLE && state_d != ST_END && cur_write_q) begin
                ad_out_q <= cur_wdata_q;
                ad_oe_q <= 1'b1;
            end else begin
                ad_oe_q <= 1'b0;
            end
        end
    end

    // Completion answer for internal and external accesses
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 8'h00;
            rsp_external_q <= 1'b0;
        end else if (ce) begin
            rsp_valid_q <= 1'b0;
            if (pop && go_int) begin
                rsp_valid_q <= 1'b1;
                rsp_rdata_q <= f_write ? 8'h00 : int_rdata;
                rsp_external_q <= 1'b0;
            end else if ((state_q == ST_DATA || state_q == ST_WAIT) && finish) begin
                rsp_valid_q <= 1'b1;
                rsp_rdata_q <= cur_write_q ? 8'h00 : ad_in;
                rsp_external_q <= 1'b1;
            end
        end
    end

    // Helper: cycles spent in the reset sequence
    logic [5:0] busy_cyc_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            busy_cyc_q <= 6'h00;
        end else if (ce && reset_busy_q) begin
            busy_cyc_q <= busy_cyc_q + 6'h01;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);

    a_reset_len: assert property ($fell(reset_busy_q) |-> busy_cyc_q == 6'h1E)
        else $error("reset sequence not ten state times");
    a_reset_quiet: assert property (reset_busy_q |-> state_q == ST_IDLE && !rsp_valid_q)
        else $error("bus activity during reset sequence");
    a_int_route: assert property (pop && go_int |=> rsp_valid_q && !rsp_external_q)
        else $error("internal access not answered internally");
    a_ext_route: assert property (pop && go_ext |=> state_q == ST_ADDR)
        else $error("external access did not start a bus cycle");
    a_prog_block: assert property (program_mode_q |-> !pop)
        else $error("request taken in programming mode");
    a_adv_release: assert property (adv_mode && state_q == ST_END |-> address_valid_strobe_q)
        else $error("address valid not released at cycle end");
    a_strobe_ext: assert property (!reset_busy_q && state_q == ST_IDLE && $stable(adv_mode)
        |-> address_valid_strobe_q == adv_mode)
        else $error("address strobe active outside bus cycle");
    a_read_strobe: assert property (!rd_n_q |-> !cur_write_q && state_q inside {ST_DATA, ST_WAIT})
        else $error("read strobe outside read cycle");
    a_write_strobe: assert property (!wr_n_q |-> cur_write_q && state_q inside {ST_DATA, ST_WAIT})
        else $error("write strobe outside write cycle");
    a_wait_insert: assert property (state_q == ST_DATA && tick && !ready && may_wait
        |=> state_q == ST_WAIT)
        else $error("ready low did not insert a wait state");
    a_wait_limit: assert property (state_q == ST_WAIT && wait_lim != 2'h0
        |-> wait_cnt_q <= wait_lim)
        else $error("wait states exceed configured limit");
    a_addr_phase: assert property (state_q == ST_ADDR |-> ad_oe_q && ad_out_q == cur_addr_q[7:0])
        else $error("low address not on port during address phase");
    a_idle_strobes: assert property (state_q == ST_IDLE |-> rd_n_q && wr_n_q)
        else $error("read or write strobe active while idle");

    c_ext_read: cover property (state_q == ST_END && !cur_write_q);
    c_ext_wait_write: cover property (state_q == ST_WAIT && cur_write_q);
    c_int_access: cover property (pop && go_int);
endmodule
`default_nettype wire

// ==== dv/ebrc_ext_mem.sv ====
// External memory with address latch on the far side of the bus
`timescale 1ns/1ps
`default_nettype none
module ebrc_ext_mem (
    input wire logic clock,
    input wire logic adv_mode,
    input wire logic strobe,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic [7:0] ad_out,
    input wire logic ad_oe,
    input wire logic [7:0] addr_hi,
    input wire logic [3:0] waits,
    output logic [7:0] ad_in,
    output logic ready,
    output logic [15:0] latch_q
);
    logic [7:0] mem [0:65535];
    logic [7:0] cnt_q;
    logic active;
    assign active = !rd_n || !wr_n;
    // Capture the address while the strobe is active and the device drives it
    always @(posedge clock) begin
        if ((strobe ^ adv_mode) && ad_oe && rd_n && wr_n) begin
            latch_q <= {addr_hi, ad_out};
        end
        if (!wr_n && ad_oe) begin
            mem[latch_q] <= ad_out;
        end
        cnt_q <= active ? cnt_q + 8'h01 : 8'h00;
    end
    // Stall for the asked wait states; ready sits low when idle to be ignored
    assign ready = active ? (cnt_q > {4'h0, waits} * 8'h03) : 1'b0;
    // Bus level with the strong pull-ups when nobody drives
    assign ad_in = ad_oe ? ad_out : (!rd_n ? mem[latch_q] : 8'hFF);
endmodule
`default_nettype wire

// ==== dv/tb_external_bus_reset_control.sv ====
// Testbench for the external bus and reset control block
`timescale 1ns/1ps
`default_nettype none
module tb_external_bus_reset_control;
    logic clock, resetn, ce, msel, prog, req_valid, req_ready, req_write;
    logic [2:0] cfg;
    logic [15:0] req_addr, latch_q;
    logic [7:0] req_wdata, int_rdata, rsp_rdata_q, retain_wdata, retain_rdata;
    logic [7:0] ad_in, ad_out_q, addr_hi_out_q;
    logic rsp_valid_q, rsp_external_q, retain_we, rsp_ext, ready;
    logic bus_clock_output_q, address_valid_strobe_q, rd_n_q, wr_n_q;
    logic ad_oe_q, addr_hi_oe_q, reset_busy_q, program_mode_q;
    logic [3:0] retain_addr, waits;
    logic [7:0] rsp_q [$];
    int err_total, compares, rd_cyc, wr_cyc, stb_cyc, clk_cyc, rsp_cnt, hi_cyc;

    ebrc_external_bus i_ebrc_external_bus (.clock(clock), .resetn(resetn), .ce(ce),
        .memory_select_input(msel), .prog_voltage_detect(prog),
        .chip_configuration_register(cfg), .req_valid(req_valid), .req_ready(req_ready),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid_q(rsp_valid_q), .rsp_rdata_q(rsp_rdata_q),
        .rsp_external_q(rsp_external_q), .int_rdata(int_rdata), .retain_we(retain_we),
        .retain_addr(retain_addr), .retain_wdata(retain_wdata),
        .retain_rdata(retain_rdata), .bus_clock_output_q(bus_clock_output_q),
        .address_valid_strobe_q(address_valid_strobe_q), .rd_n_q(rd_n_q), .wr_n_q(wr_n_q),
        .ready_unused_n(), .ready(ready), .ad_in(ad_in), .ad_out_q(ad_out_q),
        .ad_oe_q(ad_oe_q), .addr_hi_out_q(addr_hi_out_q), .addr_hi_oe_q(addr_hi_oe_q),
        .reset_busy_q(reset_busy_q), .program_mode_q(program_mode_q));
    ebrc_ext_mem i_ebrc_ext_mem (.clock(clock), .adv_mode(cfg[0]),
        .strobe(address_valid_strobe_q), .rd_n(rd_n_q), .wr_n(wr_n_q), .ad_out(ad_out_q),
        .ad_oe(ad_oe_q), .addr_hi(addr_hi_out_q), .waits(waits), .ad_in(ad_in),
        .ready(ready), .latch_q(latch_q));

    // Clock at 20 MHz
    always #25 clock = ~clock;
    // Count strobe cycles and collect answers where outputs are settled
    always @(negedge clock) begin
        if (rd_n_q === 1'b0) rd_cyc++;
        if (wr_n_q === 1'b0) wr_cyc++;
        if ((address_valid_strobe_q ^ cfg[0]) === 1'b1) stb_cyc++;
        if (bus_clock_output_q === 1'b1) clk_cyc++;
        if (addr_hi_oe_q === 1'b1) hi_cyc++;
        if (rsp_valid_q === 1'b1) begin
            rsp_cnt++;
            rsp_q.push_back(rsp_rdata_q);
            rsp_ext = rsp_external_q;
        end
    end
    // Compare and count
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // Print counts and verdict
    task automatic end_sim();
        $display("compares %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Clear monitor counts
    task automatic clr();
        rd_cyc = 0;
        wr_cyc = 0;
        stb_cyc = 0;
        clk_cyc = 0;
        hi_cyc = 0;
        rsp_q.delete();
    endtask
    // Hold a request until an edge takes it; valid stays up for back to back use
    task automatic push(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int n;
        n = 0;
        req_write = wr;
        req_addr = a;
        req_wdata = d;
        req_valid = 1'b1;
        @(negedge clock);
        while (req_ready !== 1'b1 && n < 100) begin
            @(negedge clock);
            n++;
        end
        @(posedge clock);
        #2;
    endtask
    // Wait for a total number of answers, then for the cycle to close
    task automatic wait_rsp(input int k);
        int n;
        n = 0;
        req_valid = 1'b0;
        while (rsp_cnt < k && n < 3000) begin
            @(posedge clock);
            n++;
        end
        repeat (4) @(posedge clock);
        #2;
        check("answers", 16'(rsp_cnt), 16'(k));
    endtask
    // One access from push to answer
    task automatic acc(input logic wr, input logic [15:0] a, input logic [7:0] d);
        int k;
        k = rsp_cnt + 1;
        push(wr, a, d);
        wait_rsp(k);
    endtask
    // Second reset mid-run with standby bytes and the sequence length
    task automatic t_reset();
        int n;
        retain_addr = 4'hF;
        retain_wdata = 8'hC3;
        retain_we = 1'b1;
        @(posedge clock);
        #2 retain_we = 1'b0;
        resetn = 1'b0;
        #1;
        check("strobes idle", {14'h0, rd_n_q, wr_n_q}, 16'h3);
        check("bus released", {15'h0, ad_oe_q}, 16'h0);
        @(posedge clock);
        #2 retain_we = 1'b1;
        retain_wdata = 8'hFF;
        repeat (9) @(posedge clock);
        #2 retain_we = 1'b0;
        resetn = 1'b1;
        // Clock enable low must freeze the sequence
        ce = 1'b0;
        repeat (6) @(posedge clock);
        #2 ce = 1'b1;
        clr();
        n = 0;
        @(negedge clock);
        while (reset_busy_q === 1'b1 && n < 100) begin
            n++;
            @(negedge clock);
        end
        @(posedge clock);
        #2;
        check("sequence cycles", 16'(n), 16'h1E);
        check("bus clock pulses", 16'(clk_cyc), 16'hA);
        check("standby byte", {8'h00, retain_rdata}, 16'h00C3);
    endtask
    // External write then read back in one strobe style
    task automatic t_ext(input logic mode, input logic ms, input logic [15:0] a);
        logic [7:0] d;
        d = a[7:0] ^ a[15:8] ^ 8'h3C;
        cfg = {2'b00, mode};
        msel = ms;
        waits = 4'h0;
        clr();
        acc(1'b1, a, d);
        check("write strobe cycles", 16'(wr_cyc), 16'h3);
        check("read strobe in write", 16'(rd_cyc), 16'h0);
        check("stored byte", {8'h00, i_ebrc_ext_mem.mem[a]}, {8'h00, d});
        clr();
        acc(1'b0, a, 8'h00);
        check("read byte", {8'h00, rsp_q[0]}, {8'h00, d});
        check("external flag", {15'h0, rsp_ext}, 16'h1);
        check("write strobe in read", 16'(wr_cyc), 16'h0);
        check("latched address", latch_q, a);
        check("high address cycles", 16'(hi_cyc), 16'h9);
        check("strobe cycles", 16'(stb_cyc), mode ? 16'h6 : 16'h3);
        check("idle strobe", {15'h0, address_valid_strobe_q}, {15'h0, mode});
    endtask
    // Internal accesses leave the bus still
    task automatic t_int(input logic [15:0] a, input logic [7:0] d);
        cfg = 3'h1;
        msel = 1'b1;
        int_rdata = d;
        clr();
        acc(1'b1, a, d);
        acc(1'b0, a, 8'h00);
        check("internal byte", {8'h00, rsp_q[1]}, {8'h00, d});
        check("external flag", {15'h0, rsp_ext}, 16'h0);
        check("bus activity", 16'(stb_cyc + rd_cyc + wr_cyc + hi_cyc), 16'h0);
    endtask
    // Wait states against the configured limit
    task automatic t_wait(input logic [1:0] lim, input logic [3:0] w, input logic [15:0] e);
        cfg = {lim, 1'b0};
        msel = 1'b0;
        waits = w;
        clr();
        acc(1'b0, 16'h0123, 8'h00);
        check("stretched read", 16'(rd_cyc), e);
        check("read byte", {8'h00, rsp_q[0]}, 16'h0096);
    endtask
    // Fill the queue while programming holds it, then drain against a stalling memory
    task automatic t_fifo();
        int n;
        int k;
        cfg = 3'h0;
        msel = 1'b0;
        waits = 4'h1;
        prog = 1'b1;
        repeat (2) @(posedge clock);
        #2;
        check("programming mode", {15'h0, program_mode_q}, 16'h1);
        k = rsp_cnt;
        clr();
        n = 0;
        req_write = 1'b0;
        req_addr = 16'h0500;
        req_valid = 1'b1;
        @(negedge clock);
        while (req_ready === 1'b1 && n < 20) begin
            @(posedge clock);
            #2 n++;
            req_addr = 16'h0500 + 16'(n);
            @(negedge clock);
        end
        @(posedge clock);
        #2 req_valid = 1'b0;
        check("queue depth", 16'(n), 16'h10);
        check("held while programming", 16'(rsp_cnt - k), 16'h0);
        prog = 1'b0;
        wait_rsp(k + 16);
        for (int i = 0; i < 16; i++) begin
            check("drained byte", {8'h00, rsp_q[i]}, {8'h00, 8'h40 + 8'(i)});
        end
    endtask

    // Watchdog against a hang
    initial begin
        #1000000;
        err_total++;
        $display("watchdog expired");
        end_sim();
    end
    // Main sequence
    initial begin
        clock = 1'b0;
        resetn = 1'b0;
        ce = 1'b1;
        {msel, prog, req_valid, req_write, retain_we} = 5'h00;
        {cfg, req_addr, req_wdata, int_rdata, retain_addr, retain_wdata, waits} = 0;
        {err_total, compares, rsp_cnt} = 0;
        i_ebrc_ext_mem.mem[16'h0123] = 8'h96;
        for (int i = 0; i < 16; i++) i_ebrc_ext_mem.mem[16'h0500 + i] = 8'h40 + 8'(i);
        repeat (10) @(posedge clock);
        #2 resetn = 1'b1;
        t_reset();
        $display("reset test done");
        t_fifo();
        $display("queue test done");
        t_ext(1'b0, 1'b0, 16'h2000);
        t_ext(1'b1, 1'b0, 16'h3FFF);
        t_ext(1'b0, 1'b1, 16'h1FFF);
        t_ext(1'b1, 1'b1, 16'h4000);
        $display("external test done");
        t_int(16'h2000, 8'h5A);
        t_int(16'h3FFF, 8'hA7);
        $display("internal test done");
        t_wait(2'h0, 4'h2, 16'h9);
        t_wait(2'h1, 4'h3, 16'h6);
        t_wait(2'h3, 4'h2, 16'h9);
        $display("wait test done");
        end_sim();
    end
endmodule
`default_nettype wire
